// ==== shared/stap_pkg.sv ====
package stap_pkg;

   // Scan register lengths
   localparam int unsigned IR_WIDTH    = 3;
   localparam int unsigned ID_WIDTH    = 32;
   localparam int unsigned BSCAN_WIDTH = 75;

   // Instruction codes
   localparam logic [2:0] INSTR_EXTEST   = 3'h0;
   localparam logic [2:0] INSTR_IDCODE   = 3'h1;
   localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
   localparam logic [2:0] INSTR_SAMPLE   = 3'h4;
   localparam logic [2:0] INSTR_BYPASS   = 3'h7;

   // Pattern loaded while capturing the instruction path
   localparam logic [2:0] IR_CAPTURE_PATTERN = 3'h1;
   localparam logic [1:0] IR_CAPTURE_LOW     = 2'h1;

   // Value the bypass bit takes on capture and on selection
   localparam logic BYPASS_CLEAR = 1'b0;

   // Identification word; arbitrary value, bit 0 marks presence
   localparam logic [31:0] ID_WORD_DEFAULT = 32'h0a5c3001;

   // Consecutive mode-select highs that always reach reset
   localparam logic [2:0] RESET_HIGH_EDGES = 3'h5;

   // Controller states, Gray along the usual path
   typedef enum logic [3:0] {
      ST_RESET      = 4'h0,
      ST_IDLE       = 4'h1,
      ST_SEL_DR     = 4'h3,
      ST_CAPTURE_DR = 4'h2,
      ST_SHIFT_DR   = 4'h6,
      ST_EXIT1_DR   = 4'h7,
      ST_PAUSE_DR   = 4'h5,
      ST_EXIT2_DR   = 4'h4,
      ST_UPDATE_DR  = 4'hc,
      ST_SEL_IR     = 4'hd,
      ST_CAPTURE_IR = 4'hf,
      ST_SHIFT_IR   = 4'he,
      ST_EXIT1_IR   = 4'ha,
      ST_PAUSE_IR   = 4'hb,
      ST_EXIT2_IR   = 4'h9,
      ST_UPDATE_IR  = 4'h8
   } stap_state_t;

endpackage : stap_pkg

// ==== shared/stap_link_if.sv ====
`timescale 1ns/10ps
interface stap_link_if;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;

   modport sync (output tck_rise, output tck_fall, output tms, output tdi);
   modport core (input tck_rise, input tck_fall, input tms, input tdi);
endinterface : stap_link_if

// ==== hw/stap_pin_sync.sv ====
`timescale 1ns/10ps
module stap_pin_sync (
   input  wire logic  clk,
   input  wire logic  reset,
   input  wire logic  test_clk,
   input  wire logic  mode_select,
   input  wire logic  mode_select_driven,
   input  wire logic  serial_in,
   input  wire logic  serial_in_driven,
   stap_link_if.sync  link
);

   logic [4:0] meta;
   logic [4:0] stable;
   logic       tck_prev;

   ////////////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser for all pins
   always_ff @(posedge clk) begin
      if (reset) begin
         meta   <= 5'h1b;
         stable <= 5'h1b;
      end else begin
         meta   <= {serial_in_driven, serial_in, mode_select_driven, mode_select, test_clk};
         stable <= meta;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tck_prev <= 1'b1;
      end else begin
         tck_prev <= stable[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Edges of the test clock and pulled-up data pins
   always_comb begin
      link.tck_rise = stable[0] & ~tck_prev;
      link.tck_fall = ~stable[0] & tck_prev;
      link.tms      = stable[1] | ~stable[2]; // R16
      link.tdi      = stable[3] | ~stable[4]; // R16
   end

endmodule : stap_pin_sync

// ==== hw/stap_tap.sv ====
// Overview of operation
// R1: Test port comes up in reset after power, leaving memory undisturbed.
// R2: Inputs sampled on test clock rise; outputs updated on its fall. Memory float and reset indication change one clock after the rise instead.
// R3: Mode-select, sampled each rising test clock edge, steers the state machine.
// R4: Current instruction selects the data register between serial in and out.
// R5: Serial in enters at MSB, serial out leaves from LSB.
// R6: Serial out driven only in shift states, else high-Z, changes on fall.
// R7: Five consecutive mode-select highs on rising edges force test logic reset.
// R8: Test port reset accepted anytime without touching memory accesses.
// R9: Power-up reset puts serial out in high impedance.
// R10: Exactly one scan register sits in the serial path at a time.
// R11: Three-bit instruction register shifts only when placed in the path.
// R12: Instruction becomes identification at power-up and on entering reset.
// R13: Instruction capture loads binary 01 into its two lowest bits.
// R14: One-bit bypass register gives a minimal serial path.
// R15: Bypass bit is cleared to zero when bypass takes effect.
// R16: Unconnected mode-select and serial in read as logic high.
// R17: Identification instruction captures and shifts a fixed 32-bit word.
// R18: All-zeros instruction samples the ring and floats memory outputs.
// R19: Sample-with-outputs-off selects boundary scan and floats memory outputs.
// R20: 75-bit boundary register captures the pin ring and shifts it out.
// R21: Sixteen standard controller states, transitions decided by mode-select.
`timescale 1ns/10ps
module stap_tap #(
   parameter logic [31:0] ID_WORD = stap_pkg::ID_WORD_DEFAULT
) (
   input  wire logic                              clk,
   input  wire logic                              reset,
   input  wire logic                              test_clk,
   input  wire logic                              mode_select,
   input  wire logic                              mode_select_driven,
   input  wire logic                              serial_in,
   input  wire logic                              serial_in_driven,
   input  wire logic [stap_pkg::BSCAN_WIDTH-1:0]  ring_capture,
   output logic                                   serial_out,
   output logic                                   serial_out_oe,
   output logic                                   mem_outputs_hiz,
   output logic                                   test_logic_reset
);

   stap_link_if link ();

   stap_pkg::stap_state_t                state;
   stap_pkg::stap_state_t                next_state;
   logic [stap_pkg::IR_WIDTH-1:0]        ir_shift;
   logic [stap_pkg::IR_WIDTH-1:0]        instr;
   logic                                 bypass;
   logic [stap_pkg::ID_WIDTH-1:0]        id_shift;
   logic [stap_pkg::BSCAN_WIDTH-1:0]     bscan;
   logic [2:0]                           tms_high_count;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   stap_pin_sync u_sync (
      .clk                (clk),
      .reset              (reset),
      .test_clk           (test_clk),
      .mode_select        (mode_select),
      .mode_select_driven (mode_select_driven),
      .serial_in          (serial_in),
      .serial_in_driven   (serial_in_driven),
      .link               (link.sync)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic is_shift(input stap_pkg::stap_state_t s);
      is_shift = (s == stap_pkg::ST_SHIFT_DR) || (s == stap_pkg::ST_SHIFT_IR);
   endfunction : is_shift

   function automatic logic selects_bscan(input logic [2:0] i);
      selects_bscan = (i == stap_pkg::INSTR_EXTEST) || (i == stap_pkg::INSTR_SAMPLE_Z)
                      || (i == stap_pkg::INSTR_SAMPLE);
   endfunction : selects_bscan

   // Reserved codes fall back to the bypass bit
   function automatic logic selects_bypass(input logic [2:0] i);
      selects_bypass = (i != stap_pkg::INSTR_IDCODE) && !selects_bscan(i);
   endfunction : selects_bypass

   function automatic logic floats_memory(input logic [2:0] i);
      floats_memory = (i == stap_pkg::INSTR_EXTEST) || (i == stap_pkg::INSTR_SAMPLE_Z);
   endfunction : floats_memory

   ////////////////////////////////////////////////////////////////////////////////
   // Controller transitions
   always_comb begin
      next_state = state;
      case (state) // R21
         stap_pkg::ST_RESET:      next_state = link.tms ? stap_pkg::ST_RESET      : stap_pkg::ST_IDLE;
         stap_pkg::ST_IDLE:       next_state = link.tms ? stap_pkg::ST_SEL_DR     : stap_pkg::ST_IDLE;
         stap_pkg::ST_SEL_DR:     next_state = link.tms ? stap_pkg::ST_SEL_IR     : stap_pkg::ST_CAPTURE_DR;
         stap_pkg::ST_CAPTURE_DR: next_state = link.tms ? stap_pkg::ST_EXIT1_DR   : stap_pkg::ST_SHIFT_DR;
         stap_pkg::ST_SHIFT_DR:   next_state = link.tms ? stap_pkg::ST_EXIT1_DR   : stap_pkg::ST_SHIFT_DR;
         stap_pkg::ST_EXIT1_DR:   next_state = link.tms ? stap_pkg::ST_UPDATE_DR  : stap_pkg::ST_PAUSE_DR;
         stap_pkg::ST_PAUSE_DR:   next_state = link.tms ? stap_pkg::ST_EXIT2_DR   : stap_pkg::ST_PAUSE_DR;
         stap_pkg::ST_EXIT2_DR:   next_state = link.tms ? stap_pkg::ST_UPDATE_DR  : stap_pkg::ST_SHIFT_DR;
         stap_pkg::ST_UPDATE_DR:  next_state = link.tms ? stap_pkg::ST_SEL_DR     : stap_pkg::ST_IDLE;
         stap_pkg::ST_SEL_IR:     next_state = link.tms ? stap_pkg::ST_RESET      : stap_pkg::ST_CAPTURE_IR;
         stap_pkg::ST_CAPTURE_IR: next_state = link.tms ? stap_pkg::ST_EXIT1_IR   : stap_pkg::ST_SHIFT_IR;
         stap_pkg::ST_SHIFT_IR:   next_state = link.tms ? stap_pkg::ST_EXIT1_IR   : stap_pkg::ST_SHIFT_IR;
         stap_pkg::ST_EXIT1_IR:   next_state = link.tms ? stap_pkg::ST_UPDATE_IR  : stap_pkg::ST_PAUSE_IR;
         stap_pkg::ST_PAUSE_IR:   next_state = link.tms ? stap_pkg::ST_EXIT2_IR   : stap_pkg::ST_PAUSE_IR;
         stap_pkg::ST_EXIT2_IR:   next_state = link.tms ? stap_pkg::ST_UPDATE_IR  : stap_pkg::ST_SHIFT_IR;
         stap_pkg::ST_UPDATE_IR:  next_state = link.tms ? stap_pkg::ST_SEL_DR     : stap_pkg::ST_IDLE;
         default:                 next_state = stap_pkg::ST_RESET;
      endcase
   end

   // Power-up reset lands in test logic reset
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= stap_pkg::ST_RESET; // R1
      end else if (link.tck_rise) begin
         state <= next_state; // R2 R3
      end
   end

   // Count of consecutive high mode-select samples
   always_ff @(posedge clk) begin
      if (reset) begin
         tms_high_count <= 3'h0;
      end else if (link.tck_rise) begin
         if (!link.tms) begin
            tms_high_count <= 3'h0;
         end else if (tms_high_count != stap_pkg::RESET_HIGH_EDGES) begin
            tms_high_count <= tms_high_count + 3'h1; // R7
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction register
   always_ff @(posedge clk) begin
      if (reset) begin
         ir_shift <= stap_pkg::INSTR_IDCODE;
      end else if (link.tck_rise) begin
         if (state == stap_pkg::ST_CAPTURE_IR) begin
            ir_shift <= stap_pkg::IR_CAPTURE_PATTERN; // R13
         end else if (state == stap_pkg::ST_SHIFT_IR) begin
            ir_shift <= {link.tdi, ir_shift[stap_pkg::IR_WIDTH-1:1]}; // R5 R11
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         instr <= stap_pkg::INSTR_IDCODE; // R12
      end else if (link.tck_rise) begin
         if (next_state == stap_pkg::ST_RESET) begin
            instr <= stap_pkg::INSTR_IDCODE; // R12
         end else if (state == stap_pkg::ST_UPDATE_IR) begin
            instr <= ir_shift;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data registers
   always_ff @(posedge clk) begin
      if (reset) begin
         bypass <= stap_pkg::BYPASS_CLEAR;
      end else if (link.tck_rise) begin
         if (state == stap_pkg::ST_UPDATE_IR && ir_shift == stap_pkg::INSTR_BYPASS) begin
            bypass <= stap_pkg::BYPASS_CLEAR; // R15
         end else if (state == stap_pkg::ST_CAPTURE_DR && selects_bypass(instr)) begin
            bypass <= stap_pkg::BYPASS_CLEAR; // R15
         end else if (state == stap_pkg::ST_SHIFT_DR && selects_bypass(instr)) begin
            bypass <= link.tdi; // R14
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         id_shift <= '0;
      end else if (link.tck_rise && instr == stap_pkg::INSTR_IDCODE) begin
         if (state == stap_pkg::ST_CAPTURE_DR) begin
            id_shift <= ID_WORD; // R17
         end else if (state == stap_pkg::ST_SHIFT_DR) begin
            id_shift <= {link.tdi, id_shift[stap_pkg::ID_WIDTH-1:1]}; // R5 R17
         end
      end
   end

   // Capture only; update has no preload effect
   always_ff @(posedge clk) begin
      if (reset) begin
         bscan <= '0;
      end else if (link.tck_rise && selects_bscan(instr)) begin
         if (state == stap_pkg::ST_CAPTURE_DR) begin
            bscan <= ring_capture; // R20 R18 R19
         end else if (state == stap_pkg::ST_SHIFT_DR) begin
            bscan <= {link.tdi, bscan[stap_pkg::BSCAN_WIDTH-1:1]}; // R5 R20
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial output, falling edge of the test clock
   always_ff @(posedge clk) begin
      if (reset) begin
         serial_out    <= 1'b0;
         serial_out_oe <= 1'b0; // R9
      end else if (link.tck_fall) begin
         serial_out_oe <= is_shift(state); // R6
         if (state == stap_pkg::ST_SHIFT_IR) begin
            serial_out <= ir_shift[0]; // R5
         end else if (instr == stap_pkg::INSTR_IDCODE) begin
            serial_out <= id_shift[0]; // R4 R10
         end else if (selects_bscan(instr)) begin
            serial_out <= bscan[0]; // R4 R10
         end else begin
            serial_out <= bypass; // R4 R10
         end
      end
   end

   // Memory output float and reset indication; never touches accesses otherwise
   always_ff @(posedge clk) begin
      if (reset) begin
         mem_outputs_hiz  <= 1'b0; // R8
         test_logic_reset <= 1'b1;
      end else begin
         mem_outputs_hiz  <= floats_memory(instr); // R18 R19
         test_logic_reset <= (state == stap_pkg::ST_RESET);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_reset_state;
      @(posedge clk) reset |=> (state == stap_pkg::ST_RESET) && !serial_out_oe && !mem_outputs_hiz;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("power-up reset not clean"); // R1

   property p_rise_only;
      @(posedge clk) disable iff (reset) (state != $past(state)) |-> $past(link.tck_rise);
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("state moved without test clock rise"); // R2

   property p_fall_only;
      @(posedge clk) disable iff (reset)
         (serial_out != $past(serial_out)) || (serial_out_oe != $past(serial_out_oe)) |-> $past(link.tck_fall);
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("serial out moved without falling edge"); // R2

   property p_oe_shift;
      @(posedge clk) disable iff (reset) link.tck_fall |=> (serial_out_oe == is_shift($past(state)));
   endproperty
   a_oe_shift: assert property (p_oe_shift) else $error("serial out enable wrong for state"); // R6

   property p_five_high;
      @(posedge clk) disable iff (reset) (tms_high_count == stap_pkg::RESET_HIGH_EDGES) |-> (state == stap_pkg::ST_RESET);
   endproperty
   a_five_high: assert property (p_five_high) else $error("five high samples did not reset"); // R7

   property p_reset_idcode;
      @(posedge clk) disable iff (reset) (state == stap_pkg::ST_RESET) |-> (instr == stap_pkg::INSTR_IDCODE);
   endproperty
   a_reset_idcode: assert property (p_reset_idcode) else $error("instruction not identification in reset"); // R12

   property p_ir_capture;
      @(posedge clk) disable iff (reset)
         link.tck_rise && (state == stap_pkg::ST_CAPTURE_IR) |=> (ir_shift[1:0] == stap_pkg::IR_CAPTURE_LOW);
   endproperty
   a_ir_capture: assert property (p_ir_capture) else $error("instruction capture pattern wrong"); // R13

   property p_ir_hold;
      @(posedge clk) disable iff (reset)
         (ir_shift != $past(ir_shift)) |->
         $past(link.tck_rise) && ($past(state) == stap_pkg::ST_CAPTURE_IR || $past(state) == stap_pkg::ST_SHIFT_IR);
   endproperty
   a_ir_hold: assert property (p_ir_hold) else $error("instruction register moved outside its path"); // R11

   property p_bypass_clear;
      @(posedge clk) disable iff (reset)
         link.tck_rise && (state == stap_pkg::ST_CAPTURE_DR) && (instr == stap_pkg::INSTR_BYPASS) |=> !bypass;
   endproperty
   a_bypass_clear: assert property (p_bypass_clear) else $error("bypass bit not cleared"); // R15

   property p_id_capture;
      @(posedge clk) disable iff (reset)
         link.tck_rise && (state == stap_pkg::ST_CAPTURE_DR) && (instr == stap_pkg::INSTR_IDCODE) |=> (id_shift == ID_WORD);
   endproperty
   a_id_capture: assert property (p_id_capture) else $error("identification word not captured"); // R17

   property p_id_shift;
      @(posedge clk) disable iff (reset)
         link.tck_rise && (state == stap_pkg::ST_SHIFT_DR) && (instr == stap_pkg::INSTR_IDCODE) |=>
         (id_shift[30:0] == $past(id_shift[31:1])) && (id_shift[31] == $past(link.tdi));
   endproperty
   a_id_shift: assert property (p_id_shift) else $error("identification shift direction wrong"); // R5

   property p_bscan_capture;
      @(posedge clk) disable iff (reset)
         link.tck_rise && (state == stap_pkg::ST_CAPTURE_DR) && selects_bscan(instr) |=> (bscan == $past(ring_capture));
   endproperty
   a_bscan_capture: assert property (p_bscan_capture) else $error("pin ring not captured"); // R20

   property p_mem_float;
      @(posedge clk) disable iff (reset) ##1 (mem_outputs_hiz == floats_memory($past(instr)));
   endproperty
   a_mem_float: assert property (p_mem_float) else $error("memory float does not follow instruction"); // R18

   property p_reset_no_float;
      @(posedge clk) disable iff (reset)
         (state == stap_pkg::ST_RESET) ##1 (state == stap_pkg::ST_RESET) |-> !mem_outputs_hiz;
   endproperty
   a_reset_no_float: assert property (p_reset_no_float) else $error("test reset disturbs memory"); // R8

   property p_bypass_out;
      @(posedge clk) disable iff (reset)
         link.tck_fall && (state == stap_pkg::ST_SHIFT_DR) && (instr == stap_pkg::INSTR_BYPASS) |=>
         (serial_out == $past(bypass)) && serial_out_oe;
   endproperty
   a_bypass_out: assert property (p_bypass_out) else $error("bypass bit not on serial out"); // R10

endmodule : stap_tap

// ==== bench/stap_tester.sv ====
`timescale 1ns/10ps
module stap_tester (
   input  wire logic clk,
   input  wire logic serial_out,
   input  wire logic serial_out_oe,
   output logic      test_clk,
   output logic      mode_select,
   output logic      serial_in,
   output logic      seen_strobe,
   output logic      seen_oe,
   output logic      seen_data
);
   initial begin
      test_clk    = 1'b0;
      mode_select = 1'b1;
      serial_in   = 1'b1;
      seen_strobe = 1'b0;
      seen_oe     = 1'b0;
      seen_data   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One test clock period: low half then high half, 80 ns
   task automatic clock_bit(input logic tms, input logic tdi);
      @(posedge clk);
      #1;
      test_clk    = 1'b0;
      mode_select = tms;
      serial_in   = tdi;
      repeat (5) @(posedge clk);
      #1;
      seen_oe     = serial_out_oe;
      seen_data   = serial_out_oe ? serial_out : 1'bz;
      seen_strobe = 1'b1;
      test_clk    = 1'b1;
      @(posedge clk);
      #1;
      seen_strobe = 1'b0;
      repeat (3) @(posedge clk);
   endtask : clock_bit

   // Clock stands low between frames; released data line toggles
   task automatic park();
      @(posedge clk);
      #1;
      test_clk  = 1'b0;
      serial_in = ~serial_in;
   endtask : park
endmodule : stap_tester

// ==== bench/stap_tap_test.sv ====
`timescale 1ns/10ps
module stap_tap_test;
   typedef struct packed {logic oe; logic d;} stap_exp_t;
   // Arbitrary identification word for this run, bit 0 set
   localparam logic [31:0] ID_TEST = 32'h5a0f3c01;

   logic        clk;
   logic        reset;
   logic        ms_drv;
   logic        si_drv;
   logic [74:0] ring;
   logic        test_clk;
   logic        mode_select;
   logic        serial_in;
   logic        serial_out;
   logic        serial_out_oe;
   logic        mem_outputs_hiz;
   logic        test_logic_reset;
   logic        seen_strobe;
   logic        seen_oe;
   logic        seen_data;
   logic [31:0] seed;
   logic [79:0] din;
   logic [79:0] rv;
   logic [2:0]  codes [6];
   int          mismatches;
   int          tests_run;
   stap_exp_t   exp_q[$];
   stap_exp_t   cur;

   stap_tap #(.ID_WORD(ID_TEST)) DUT (
      .clk(clk), .reset(reset), .test_clk(test_clk), .mode_select(mode_select),
      .mode_select_driven(ms_drv), .serial_in(serial_in), .serial_in_driven(si_drv),
      .ring_capture(ring), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .mem_outputs_hiz(mem_outputs_hiz), .test_logic_reset(test_logic_reset));

   stap_tester tester (
      .clk(clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .test_clk(test_clk),
      .mode_select(mode_select), .serial_in(serial_in), .seen_strobe(seen_strobe),
      .seen_oe(seen_oe), .seen_data(seen_data));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   function automatic logic [79:0] dr_expect(input logic [2:0] c, input logic [79:0] d);
      if (c == stap_pkg::INSTR_EXTEST || c == stap_pkg::INSTR_SAMPLE_Z || c == stap_pkg::INSTR_SAMPLE)
         return {d[4:0], ring};
      if (c == stap_pkg::INSTR_IDCODE)
         return {d[47:0], ID_TEST};
      return {d[78:0], stap_pkg::BYPASS_CLEAR};
   endfunction : dr_expect

   task automatic check(input string name, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", name, e, g);
      end
   endtask : check

   task automatic roll(output logic [79:0] v);
      for (int j = 0; j < 80; j++) begin
         seed = lfsr_next(seed);
         v    = {v[78:0], seed[0]};
      end
   endtask : roll

   task automatic step(input logic tms, input logic tdi, input logic eoe, input logic ed);
      exp_q.push_back({eoe, ed});
      tester.clock_bit(tms, tdi);
   endtask : step

   task automatic settle();
      tester.park();
      repeat (6) @(posedge clk);
      #1;
   endtask : settle

   // From idle through one shift of n bits, back to idle
   task automatic scan(input int n, input logic [79:0] d, input logic [79:0] e, input logic is_ir);
      step(1'b1, 1'b0, 1'b0, 1'b0);
      if (is_ir) step(1'b1, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < n; i++) step(1'(i == n - 1), d[i], 1'b1, e[i]);
      step(1'b1, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      settle();
   endtask : scan

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (seen_strobe === 1'b1 && exp_q.size() > 0) begin
         cur = exp_q.pop_front();
         check("serial out enable", cur.oe, seen_oe);
         if (cur.oe) check("serial out data", cur.d, seen_data);
      end
   end

   initial begin
      #400000;
      mismatches++;
      close_out();
   end

   initial begin
      reset      = 1'b1;
      ms_drv     = 1'b1;
      si_drv     = 1'b1;
      ring       = '0;
      seed       = 32'h913ba83f;
      mismatches = 0;
      tests_run  = 0;
      codes      = '{stap_pkg::INSTR_IDCODE, stap_pkg::INSTR_EXTEST, stap_pkg::INSTR_SAMPLE_Z,
                     stap_pkg::INSTR_SAMPLE, stap_pkg::INSTR_BYPASS, 3'h3};
      repeat (5) @(posedge clk);
      #1;
      reset = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check("test logic reset", 1'b1, test_logic_reset);
      check("serial out enable", 1'b0, serial_out_oe);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      foreach (codes[k]) begin
         if (k > 0) scan(3, {77'h0, codes[k]}, 80'h1, 1'b1);
         check("memory float", 1'(codes[k] == 3'h0 || codes[k] == 3'h2), mem_outputs_hiz);
         roll(rv);
         @(posedge clk);
         #1;
         ring = rv[74:0];
         roll(din);
         scan(80, din, dr_expect(codes[k], din), 1'b0);
      end
      // Undriven serial input reads high through the bypass bit
      si_drv = 1'b0;
      roll(din);
      scan(4, din, 80'he, 1'b0);
      si_drv = 1'b1;
      // Mode-select reset from the middle of a boundary shift
      scan(3, 80'h0, 80'h1, 1'b1);
      check("memory float", 1'b1, mem_outputs_hiz);
      step(1'b1, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 3; i++) step(1'b0, din[i], 1'b1, ring[i]);
      step(1'b1, 1'b0, 1'b1, ring[3]);
      for (int i = 0; i < 3; i++) step(1'b1, 1'b0, 1'b0, 1'b0);
      settle();
      check("test logic reset", 1'b0, test_logic_reset);
      step(1'b1, 1'b0, 1'b0, 1'b0);
      settle();
      check("test logic reset", 1'b1, test_logic_reset);
      check("memory float", 1'b0, mem_outputs_hiz);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      roll(din);
      scan(80, din, dr_expect(stap_pkg::INSTR_IDCODE, din), 1'b0);
      // Floating mode-select walks to reset whatever the line shows
      ms_drv = 1'b0;
      for (int i = 0; i < 5; i++) step(1'(i % 2), 1'b0, 1'b0, 1'b0);
      settle();
      check("test logic reset", 1'b1, test_logic_reset);
      ms_drv = 1'b1;
      // Power-up reset while the serial output is driven
      step(1'b0, 1'b0, 1'b0, 1'b0);
      step(1'b1, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b1, ID_TEST[0]);
      settle();
      check("serial out enable", 1'b1, serial_out_oe);
      @(posedge clk);
      #1;
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("serial out enable", 1'b0, serial_out_oe);
      check("test logic reset", 1'b1, test_logic_reset);
      reset = 1'b0;
      repeat (4) @(posedge clk);
      step(1'b0, 1'b0, 1'b0, 1'b0);
      roll(din);
      scan(80, din, dr_expect(stap_pkg::INSTR_IDCODE, din), 1'b0);
      repeat (20) @(posedge clk);
      close_out();
   end
endmodule : stap_tap_test
